/* inc/sdcp_pkg.sv */
package sdcp_pkg;

  // ----------------------------------------------------------------
  // command codes: {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MODE_SET    = 4'h0;
  localparam logic [3:0] CMD_REFRESH     = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE   = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE    = 4'h3;
  localparam logic [3:0] CMD_WRITE       = 4'h4;
  localparam logic [3:0] CMD_READ        = 4'h5;
  localparam logic [3:0] CMD_BURST_STOP  = 4'h6;

  // ----------------------------------------------------------------
  // mode word layout and encodings
  // ----------------------------------------------------------------
  localparam int          MODE_W         = 15;
  localparam int          MODE_LEN_LSB   = 0;
  localparam int          MODE_TYPE_BIT  = 3;
  localparam int          MODE_LAT_LSB   = 4;
  localparam int          MODE_WBM_BIT   = 9;
  localparam logic [2:0]  LEN_1          = 3'h0;
  localparam logic [2:0]  LEN_2          = 3'h1;
  localparam logic [2:0]  LEN_4          = 3'h2;
  localparam logic [2:0]  LEN_8          = 3'h3;
  localparam logic [2:0]  LEN_PAGE       = 3'h7;
  localparam logic [2:0]  LAT_3          = 3'h3;
  localparam int          AP_BIT         = 10;
  localparam logic [14:0] MODE_RESET     = 15'h0020;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int BANKS      = 4;
  localparam int ROW_W      = 13;
  localparam int COL_W      = 9;
  localparam int ADDR_W     = 13;
  localparam int DATA_W     = 16;

  // ----------------------------------------------------------------
  // timing, 40 MHz system clock
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 25;
  localparam int REFRESH_CYC_NS  = 60;
  localparam int REFRESH_CYC     = (REFRESH_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_CYCLE_NS    = 60;
  localparam int ROW_CYCLE_CYC   = (ROW_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CKE_RECOVER_CYC = 1;
  localparam int REF_PERIOD_MS   = 64;
  localparam int REF_ROWS        = 8192;
  localparam int SELF_TICK_CYC   = (REF_PERIOD_MS * 1000000 / CLK_NS) / REF_ROWS;

  // power state, gray along run -> down -> self
  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SELF = 2'b11
  } sdcp_pwr_type;

endpackage

/* rtl/sdcp_device.sv */
`timescale 1ns/100ps
module sdcp_device #(
  parameter int ROW_STORE_W = 13,
  parameter int BUF_W       = 52
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        cke_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        ras_n_in,
  input  wire logic                        cas_n_in,
  input  wire logic                        we_n_in,
  input  wire logic [1:0]                  bank_select_in,
  input  wire logic [sdcp_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                        low_byte_mask_in,
  input  wire logic                        high_byte_mask_in,
  input  wire logic [sdcp_pkg::DATA_W-1:0] data_lines_in,
  output logic      [sdcp_pkg::DATA_W-1:0] data_lines_out,
  output logic      [1:0]                  data_lines_oe_out,
  output logic      [sdcp_pkg::BANKS-1:0]  bank_open_out,
  output logic                             power_down_out,
  output logic                             self_refresh_out,
  output logic                             refresh_busy_out,
  output logic      [sdcp_pkg::ROW_W-1:0]  refresh_row_out,
  output logic                             write_buffer_ready_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // burst length as a column mask, length minus one
  function automatic logic [8:0] len_mask(input logic [2:0] code);
    case (code)
      sdcp_pkg::LEN_1:    len_mask = 9'h000;
      sdcp_pkg::LEN_2:    len_mask = 9'h001;
      sdcp_pkg::LEN_4:    len_mask = 9'h003;
      sdcp_pkg::LEN_8:    len_mask = 9'h007;
      sdcp_pkg::LEN_PAGE: len_mask = 9'h1ff;
      default:            len_mask = 9'h000;
    endcase
  endfunction

  // column of beat i: wraps inside the burst block
  function automatic logic [8:0] beat_col(input logic [8:0] base, input logic [8:0] idx,
                                          input logic [8:0] msk, input logic ilv);
    logic [8:0] low;
    low      = ilv ? (base ^ idx) : (base + idx);
    beat_col = (base & ~msk) | (low & msk);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                                  cke_r;
  sdcp_pkg::sdcp_pwr_type                pwr_r, pwr_nxt;
  logic [2:0]                            busy_r, busy_nxt;
  logic [8:0]                            tick_r;
  logic [sdcp_pkg::ROW_W-1:0]            ref_row_r;
  logic [sdcp_pkg::MODE_W-1:0]           mode_r;
  logic [sdcp_pkg::BANKS-1:0]            open_r, open_nxt;
  logic [sdcp_pkg::ROW_W-1:0]            row_r [sdcp_pkg::BANKS];
  logic                                  bact_r, bwr_r, bap_r;
  logic [1:0]                            bbank_r;
  logic [8:0]                            bbase_r, bidx_r, bmask_r;
  logic                                  s1_v_r, s2_v_r, out_v_r;
  logic [sdcp_pkg::DATA_W-1:0]           s1_d_r, s2_d_r, out_d_r;
  logic [1:0]                            dqm_d1_r, oe_r;
  logic [sdcp_pkg::DATA_W-1:0]           mem [2**(2+ROW_STORE_W+sdcp_pkg::COL_W)];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // an edge counts only when clock enable was high before it and the
  // device is neither asleep nor busy refreshing or recovering from a wake
  wire        en       = cke_r && (pwr_r == sdcp_pkg::PWR_RUN) && (busy_r == 3'h0);
  wire [3:0]  code     = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire        sel      = en && !cs_n_in;
  wire        cmd_mrs  = sel && code == sdcp_pkg::CMD_MODE_SET;
  wire        cmd_ref  = sel && code == sdcp_pkg::CMD_REFRESH;
  wire        cmd_pre  = sel && code == sdcp_pkg::CMD_PRECHARGE;
  wire        cmd_act  = sel && code == sdcp_pkg::CMD_ACTIVATE;
  wire        cmd_wr   = sel && code == sdcp_pkg::CMD_WRITE;
  wire        cmd_rd   = sel && code == sdcp_pkg::CMD_READ;
  wire        cmd_bst  = sel && code == sdcp_pkg::CMD_BURST_STOP;
  wire        ap_pin   = addr_in[sdcp_pkg::AP_BIT];

  // mode fields
  wire [2:0]  m_len    = mode_r[sdcp_pkg::MODE_LEN_LSB +: 3];
  wire        m_ilv    = mode_r[sdcp_pkg::MODE_TYPE_BIT];
  wire        m_cl3    = mode_r[sdcp_pkg::MODE_LAT_LSB +: 3] == sdcp_pkg::LAT_3;
  wire        m_single = mode_r[sdcp_pkg::MODE_WBM_BIT];

  // ----------------------------------------------------------------
  // burst engine: new command wins over a running burst
  // ----------------------------------------------------------------
  wire        new_b    = cmd_rd || cmd_wr;
  wire        cont_b   = en && bact_r && !(new_b || cmd_bst || cmd_pre);
  wire        beat_v   = new_b || cont_b;
  wire        beat_wr  = new_b ? cmd_wr : bwr_r;
  wire [1:0]  beat_bk  = new_b ? bank_select_in : bbank_r;
  wire        beat_ap  = new_b ? ap_pin : bap_r;
  wire [8:0]  new_msk  = (cmd_wr && m_single) ? 9'h000 : len_mask(m_len);
  wire [8:0]  beat_msk = new_b ? new_msk : bmask_r;
  wire [8:0]  beat_idx = new_b ? 9'h000 : bidx_r;
  wire [8:0]  beat_cl  = new_b ? addr_in[8:0] : beat_col(bbase_r, bidx_r, bmask_r, m_ilv);
  // a full-page burst wraps until stopped or interrupted
  wire        last     = (beat_idx == beat_msk) && (beat_msk != 9'h1ff);
  wire        ap_close = beat_v && last && beat_ap;
  wire [sdcp_pkg::ROW_W-1:0] beat_row = row_r[beat_bk];
  wire [2+ROW_STORE_W+sdcp_pkg::COL_W-1:0] beat_addr =
    {beat_bk, beat_row[ROW_STORE_W-1:0], beat_cl};
  wire        rd_beat  = beat_v && !beat_wr;

  // ----------------------------------------------------------------
  // two-entry write buffer: a read beat stalls the array write port
  // ----------------------------------------------------------------
  logic [BUF_W-1:0] buf_q [2];
  logic             wp_r, rp_r;
  logic [1:0]       cnt_r;
  wire              buf_in_v  = beat_v && beat_wr;
  wire              buf_in_r  = cnt_r != 2'h2;
  wire              buf_out_v = cnt_r != 2'h0;
  wire              buf_out_r = !rd_beat;
  wire              push      = buf_in_v && buf_in_r;
  wire              pop       = buf_out_v && buf_out_r;
  wire [BUF_W-1:0]  buf_word  = {{(BUF_W-29-ROW_STORE_W){1'b0}},
                                 high_byte_mask_in, low_byte_mask_in, beat_addr, data_lines_in};
  wire [BUF_W-1:0]  buf_head  = buf_q[rp_r];

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage holds no reset; byte masks gate each half
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      buf_q[wp_r] <= buf_word;
    end
    if (pop && !buf_head[16+2+ROW_STORE_W+9+1]) begin
      mem[buf_head[16 +: 2+ROW_STORE_W+9]][15:8] <= buf_head[15:8];
    end
    if (pop && !buf_head[16+2+ROW_STORE_W+9]) begin
      mem[buf_head[16 +: 2+ROW_STORE_W+9]][7:0] <= buf_head[7:0];
    end
    if (rd_beat) begin
      s1_d_r <= mem[beat_addr];
    end
  end

  // ----------------------------------------------------------------
  // bank table and burst registers
  // ----------------------------------------------------------------
  always_comb begin
    open_nxt = open_r;
    if (cmd_act) open_nxt[bank_select_in] = 1'b1;
    if (cmd_pre && ap_pin) open_nxt = '0;
    if (cmd_pre && !ap_pin) open_nxt[bank_select_in] = 1'b0;
    if (ap_close) open_nxt[beat_bk] = 1'b0;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      open_r  <= '0;
      mode_r  <= sdcp_pkg::MODE_RESET;
      bact_r  <= 1'b0;
      bwr_r   <= 1'b0;
      bap_r   <= 1'b0;
      bbank_r <= 2'h0;
      bbase_r <= 9'h000;
      bidx_r  <= 9'h000;
      bmask_r <= 9'h000;
    end else begin
      open_r <= open_nxt;
      if (cmd_mrs) mode_r <= {bank_select_in, addr_in};
      if (en) bact_r <= beat_v && !last;
      bidx_r <= (beat_idx + 9'h001) & beat_msk;
      if (new_b) begin
        bwr_r   <= cmd_wr;
        bap_r   <= ap_pin;
        bbank_r <= bank_select_in;
        bbase_r <= addr_in[8:0];
        bmask_r <= new_msk;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (cmd_act) row_r[bank_select_in] <= addr_in;
  end

  // ----------------------------------------------------------------
  // read pipe: stage one at the command edge, output after latency
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s1_v_r   <= 1'b0;
      s2_v_r   <= 1'b0;
      out_v_r  <= 1'b0;
      s2_d_r   <= '0;
      out_d_r  <= '0;
      dqm_d1_r <= 2'h3;
      oe_r     <= 2'h0;
    end else begin
      s1_v_r   <= rd_beat;
      s2_v_r   <= s1_v_r;
      s2_d_r   <= s1_d_r;
      out_v_r  <= m_cl3 ? s2_v_r : s1_v_r;
      out_d_r  <= m_cl3 ? s2_d_r : s1_d_r;
      dqm_d1_r <= {high_byte_mask_in, low_byte_mask_in};
      // mask acts two edges after it is sampled
      oe_r     <= {2{m_cl3 ? s2_v_r : s1_v_r}} & ~dqm_d1_r;
    end
  end

  assign data_lines_out    = out_d_r;
  assign data_lines_oe_out = oe_r;

  // ----------------------------------------------------------------
  // power, refresh and self refresh
  // ----------------------------------------------------------------
  always_comb begin
    pwr_nxt  = pwr_r;
    busy_nxt = (busy_r != 3'h0) ? busy_r - 3'h1 : 3'h0;
    case (pwr_r)
      sdcp_pkg::PWR_RUN: begin
        if (cmd_ref && cke_in) busy_nxt = 3'(sdcp_pkg::REFRESH_CYC);
        if (cke_r && !cke_in) begin
          pwr_nxt = (cmd_ref) ? sdcp_pkg::PWR_SELF : sdcp_pkg::PWR_DOWN;
        end
      end
      sdcp_pkg::PWR_DOWN: begin
        if (cke_in) begin
          pwr_nxt  = sdcp_pkg::PWR_RUN;
          busy_nxt = 3'(sdcp_pkg::CKE_RECOVER_CYC);
        end
      end
      sdcp_pkg::PWR_SELF: begin
        if (cke_in) begin
          pwr_nxt  = sdcp_pkg::PWR_RUN;
          busy_nxt = 3'(sdcp_pkg::ROW_CYCLE_CYC);
        end
      end
      default: pwr_nxt = sdcp_pkg::PWR_RUN;
    endcase
  end

  // internal row counter advances per refresh; in self refresh a
  // divider paces it so the whole array is covered every period
  wire self_tick = (pwr_r == sdcp_pkg::PWR_SELF) &&
                   (tick_r == 9'(sdcp_pkg::SELF_TICK_CYC - 1));

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cke_r     <= 1'b0;
      pwr_r     <= sdcp_pkg::PWR_RUN;
      busy_r    <= 3'h0;
      tick_r    <= 9'h000;
      ref_row_r <= '0;
    end else begin
      cke_r     <= cke_in;
      pwr_r     <= pwr_nxt;
      busy_r    <= busy_nxt;
      tick_r    <= (pwr_r != sdcp_pkg::PWR_SELF || self_tick) ? 9'h000 : tick_r + 9'h001;
      if (cmd_ref || self_tick) ref_row_r <= ref_row_r + 13'h0001;
    end
  end

  assign bank_open_out          = open_r;
  assign power_down_out         = pwr_r == sdcp_pkg::PWR_DOWN;
  assign self_refresh_out       = pwr_r == sdcp_pkg::PWR_SELF;
  assign refresh_busy_out       = busy_r != 3'h0;
  assign refresh_row_out        = ref_row_r;
  assign write_buffer_ready_out = buf_in_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mode_store: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_mrs |=> mode_r == $past({bank_select_in, addr_in}))
    else $error("mode word not stored");
  a_act_opens: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_act && !ap_close |=> open_r[$past(bank_select_in)])
    else $error("activate did not open bank");
  a_pre_all: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_pre && ap_pin |=> open_r == 4'h0)
    else $error("precharge all left a bank open");
  a_read_lat2: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_rd && !m_cl3 && !cmd_mrs |-> ##2 out_v_r)
    else $error("read data late at latency two");
  a_read_lat3: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_rd && m_cl3 |-> ##1 (!cmd_mrs) ##2 out_v_r)
    else $error("read data late at latency three");
  a_ap_close: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ap_close && !cmd_act |=> !open_r[$past(beat_bk)])
    else $error("auto precharge left bank open");
  a_refresh_busy: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_ref && cke_in |=> refresh_busy_out [*3] ##1 !refresh_busy_out)
    else $error("refresh busy time wrong");
  a_self_entry: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_ref && !cke_in |=> self_refresh_out)
    else $error("self refresh not entered");
  a_deselect_nop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cs_n_in && !bact_r |=> $stable(mode_r) && $stable(open_r))
    else $error("deselect changed state");
  a_sleep_freeze: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    power_down_out && !cke_in |=> $stable(open_r) && !out_v_r [*1])
    else $error("power down did not freeze");
  a_mask_float: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dqm_d1_r[0] |=> !data_lines_oe_out[0])
    else $error("masked byte driven");

endmodule

/* tb/sdcp_ctrl_model.sv */
`timescale 1ns/100ps
// --------------------------------------------------------------
// controller model: one command per call, then no-operation cycles
// --------------------------------------------------------------
module sdcp_ctrl_model (
  input  wire logic                        clk_in,
  output logic                             cke_out,
  output logic [3:0]                       cmd_out,
  output logic [1:0]                       bank_out,
  output logic [sdcp_pkg::ADDR_W-1:0]      addr_out,
  output logic [1:0]                       mask_out,
  output logic [sdcp_pkg::DATA_W-1:0]      data_out
);
  localparam logic [3:0] NOP = 4'h7;
  int                    seed = 42972;

  // idle bus at time zero, clock enabled
  initial begin
    cke_out  = 1'b1;
    cmd_out  = NOP;
    bank_out = 2'h0;
    addr_out = 13'h0000;
    mask_out = 2'h0;
    data_out = 16'h0000;
  end

  // callers space commands by the device timing in whole clocks; the run
  // stays far inside one refresh period, so no refresh quota is owed
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic k = 1'b1, input logic [15:0] d0 = 16'h0000,
                       input logic [15:0] d1 = 16'h0000, input logic [1:0] m1 = 2'h0);
    @(posedge clk_in);
    cke_out  <= k;
    cmd_out  <= c;
    bank_out <= b;
    addr_out <= a;
    data_out <= d0;
    mask_out <= 2'h0;
    @(posedge clk_in);
    // don't-care fields go random in the filler cycle
    cmd_out  <= NOP;
    bank_out <= 2'($random(seed));
    addr_out <= 13'($random(seed));
    data_out <= (c == sdcp_pkg::CMD_WRITE) ? d1 : 16'($random(seed));
    mask_out <= m1;
    if (c == sdcp_pkg::CMD_WRITE) begin
      @(posedge clk_in);
      data_out <= ~d1; // released lines never keep the last word
      mask_out <= 2'h0;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
endmodule

/* tb/sdcp_device_bench.sv */
`timescale 1ns/100ps
module sdcp_device_bench;
  localparam logic [3:0] RD = sdcp_pkg::CMD_READ;
  localparam logic [3:0] ACT = sdcp_pkg::CMD_ACTIVATE;
  localparam logic [3:0] PRE = sdcp_pkg::CMD_PRECHARGE;
  localparam logic [3:0] REF = sdcp_pkg::CMD_REFRESH;
  localparam logic [3:0] MODE_SET_CMD = sdcp_pkg::CMD_MODE_SET;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        cke;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic [12:0] addr;
  logic [1:0]  mask;
  logic [15:0] din;
  logic [15:0] dout;
  logic [1:0]  oe;
  logic [3:0]  open;
  logic        pd;
  logic        sr;
  logic        busy;
  logic [12:0] row;
  logic        wb_rdy;
  logic [15:0] mem [int];
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          seed       = 42972;
  int          lat        = 2;
  logic        single     = 1'b0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  sdcp_ctrl_model ctrl (.clk_in(clk_sys_in), .cke_out(cke), .cmd_out(cmd), .bank_out(bank),
                        .addr_out(addr), .mask_out(mask), .data_out(din));

  // small row store keeps the array cheap; one row per bank is used
  sdcp_device #(.ROW_STORE_W(3)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cke_in(cke), .cs_n_in(cmd[3]),
    .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .bank_select_in(bank),
    .addr_in(addr), .low_byte_mask_in(mask[0]), .high_byte_mask_in(mask[1]),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe_out(oe),
    .bank_open_out(open), .power_down_out(pd), .self_refresh_out(sr),
    .refresh_busy_out(busy), .refresh_row_out(row), .write_buffer_ready_out(wb_rdy));

  // --------------------------------------------------------------
  // checking and verdict
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // burst helpers, length two; the model merges masked bytes
  // --------------------------------------------------------------
  task automatic wr(input int b, input int c, input logic ap, input logic [1:0] m1);
    logic [15:0] d0;
    logic [15:0] d1;
    int          k;
    d0 = 16'($random(seed));
    d1 = 16'($random(seed));
    k = b * 512 + (c ^ 1);
    mem[b * 512 + c] = d0;
    // single-word write mode leaves the second column alone
    if (!single) begin
      mem[k] = {m1[1] ? mem[k][15:8] : d1[15:8], m1[0] ? mem[k][7:0] : d1[7:0]};
    end
    ctrl.issue(sdcp_pkg::CMD_WRITE, b[1:0], {2'h0, ap, 1'b0, c[8:0]}, 1'b1, d0, d1, m1);
    ctrl.idle(6);
  endtask

  task automatic rd(input int b, input int c, input logic ap);
    ctrl.issue(RD, b[1:0], {2'h0, ap, 1'b0, c[8:0]});
    repeat (lat - 1) @(posedge clk_sys_in);
    #1;
    check("read word0", {14'h0, oe, dout}, {14'h0, 2'h3, mem[b * 512 + c]});
    @(posedge clk_sys_in);
    #1;
    check("read word1", {14'h0, oe, dout}, {14'h0, 2'h3, mem[b * 512 + (c ^ 1)]});
    @(posedge clk_sys_in);
    #1;
    check("read end", {30'h0, oe}, 32'h0);
    ctrl.idle(4);
  endtask

  // hang guard, far beyond the five hundred or so cycles the run needs
  initial begin
    #(20000 * 25);
    n_mismatch++;
    give_verdict();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    check("reset flags", {12'h0, open, pd, sr, busy, row}, 32'h0);
    ctrl.idle(2);
    ctrl.issue(MODE_SET_CMD, 2'h0, 13'h0021);
    ctrl.idle(2);
    for (int b = 0; b < 4; b++) begin
      ctrl.issue(ACT, b[1:0], 13'($random(seed)));
      ctrl.idle(3);
    end
    #1;
    check("all open", {28'h0, open}, 32'hf);
    wr(0, 10, 1'b0, 2'h0);
    rd(0, 10, 1'b0);
    wr(0, 10, 1'b0, 2'h2);
    rd(0, 10, 1'b0);
    check("write buffer", {31'h0, wb_rdy}, 32'h1);
    wr(1, 301, 1'b1, 2'h0);
    // full write first, so the masked byte below keeps a known value
    wr(2, 7, 1'b0, 2'h0);
    wr(2, 7, 1'b0, 2'h1);
    rd(2, 7, 1'b1);
    #1;
    check("auto close", {28'h0, open}, 32'h9);
    // deselect with random strobes must leave closed banks closed
    ctrl.issue({1'b1, 3'($random(seed))}, 2'h1, 13'($random(seed)));
    ctrl.idle(3);
    ctrl.issue(PRE, 2'h3, 13'h0000);
    ctrl.idle(3);
    #1;
    check("deselect and one close", {28'h0, open}, 32'h1);
    ctrl.issue(PRE, 2'h2, 13'h0400);
    ctrl.idle(3);
    #1;
    check("close all", {28'h0, open}, 32'h0);
    // latency three, single-word writes, interleaved order
    ctrl.issue(MODE_SET_CMD, 2'h0, 13'h0239);
    ctrl.idle(2);
    lat = 3;
    single = 1'b1;
    ctrl.issue(ACT, 2'h3, 13'($random(seed)));
    ctrl.idle(3);
    wr(3, 101, 1'b0, 2'h0);
    wr(3, 100, 1'b0, 2'h0);
    rd(3, 100, 1'b1);
    ctrl.issue(REF, 2'($random(seed)), 13'($random(seed)));
    for (int i = 0; i < 4; i++) begin
      #1;
      check("refresh busy", {31'h0, busy}, {31'h0, i < 3});
      @(posedge clk_sys_in);
    end
    check("refresh row", {19'h0, row}, 32'h1);
    ctrl.issue(REF, 2'($random(seed)), 13'($random(seed)), 1'b0);
    ctrl.idle(3);
    #1;
    check("self refresh", {30'h0, sr, pd}, 32'h2);
    // the internal divider must step the row while asleep
    ctrl.idle(sdcp_pkg::SELF_TICK_CYC - 2);
    #1;
    check("self refresh row", {19'h0, row}, 32'h3);
    ctrl.issue(4'h7, 2'($random(seed)), 13'($random(seed)));
    ctrl.idle(6);
    ctrl.issue(4'h7, 2'($random(seed)), 13'($random(seed)), 1'b0);
    ctrl.issue(ACT, 2'h0, 13'h0001, 1'b0);
    ctrl.idle(2);
    #1;
    check("power down", {26'h0, sr, pd, open}, 32'h10);
    ctrl.issue(4'h7, 2'($random(seed)), 13'($random(seed)));
    ctrl.idle(3);
    #1;
    check("power up", {26'h0, sr, pd, open}, 32'h0);
    ctrl.issue(MODE_SET_CMD, 2'h0, 13'h0023);
    ctrl.idle(2);
    ctrl.issue(ACT, 2'h0, 13'($random(seed)));
    ctrl.idle(3);
    ctrl.issue(RD, 2'h0, 13'h0000);
    ctrl.issue(sdcp_pkg::CMD_BURST_STOP, 2'($random(seed)), 13'($random(seed)));
    @(posedge clk_sys_in);
    #1;
    check("burst stop", {30'h0, oe}, 32'h0);
    give_verdict();
  end
endmodule
